// ===== core/row_spacing_pkg.sv
// Purpose: Shared constants and types for row open / row close spacing
// Assumes: Two bank sets picked by bank address bit 0; gaps in clock periods
// Notes: Link runs on the single reference clock
package row_spacing_pkg;
   localparam int SETS = 2;
   localparam int BANK_W = 3;
   localparam int SET_BIT = 0;
   localparam int AGE_W = 4;
   localparam logic [AGE_W-1:0] AGE_MAX = 4'hF;
   localparam logic [AGE_W-1:0] AGE_ONE = 4'h1;
   // Clock period of the link, ns
   localparam int CLOCK_PERIOD_NS = 10;
   // Gaps as printed, in clock periods
   localparam int OPEN_GAP_SAME_CP = 4;
   localparam int OPEN_GAP_CROSS_CP = 4;
   localparam int CLOSE_GAP_SAME_CP = 4;
   localparam int CLOSE_GAP_CROSS_CP = 1;
   localparam int DEV_MIN_OPEN_CROSS_CP = 4;
   localparam int DEV_MIN_CLOSE_CROSS_CP = 1;
   // Gap counts in cycles; one clock period per cycle
   localparam logic [AGE_W-1:0] OPEN_GAP_SAME = AGE_W'(OPEN_GAP_SAME_CP);
   localparam logic [AGE_W-1:0] OPEN_GAP_CROSS = AGE_W'(OPEN_GAP_CROSS_CP);
   localparam logic [AGE_W-1:0] CLOSE_GAP_SAME = AGE_W'(CLOSE_GAP_SAME_CP);
   localparam logic [AGE_W-1:0] CLOSE_GAP_CROSS = AGE_W'(CLOSE_GAP_CROSS_CP);
   localparam logic [AGE_W-1:0] DEV_MIN_OPEN_CROSS = AGE_W'(DEV_MIN_OPEN_CROSS_CP);
   localparam logic [AGE_W-1:0] DEV_MIN_CLOSE_CROSS = AGE_W'(DEV_MIN_CLOSE_CROSS_CP);
   typedef enum logic [1:0]
   {
      KIND_IDLE = 2'h0,
      KIND_OPEN = 2'h1,
      KIND_CLOSE = 2'h3
   } pkt_kind_t;
endpackage

// ===== core/row_link_if.sv
// Purpose: Request packet link between controller and memory device
// Assumes: Both ends clocked by the same reference clock
// Notes: Packet fields stand for one cycle with pkt_valid
`timescale 1ns/10ps
interface row_link_if;
   logic pkt_valid;
   row_spacing_pkg::pkt_kind_t pkt_kind;
   logic [row_spacing_pkg::BANK_W-1:0] pkt_bank;
   logic pkt_delay;
   logic pkt_refresh;
   logic pkt_dual;
   logic [row_spacing_pkg::BANK_W-1:0] pkt_bank2;
   modport ctrl (
      output pkt_valid,
      output pkt_kind,
      output pkt_bank,
      output pkt_delay,
      output pkt_refresh,
      output pkt_dual,
      output pkt_bank2
   );
   modport dev (
      input pkt_valid,
      input pkt_kind,
      input pkt_bank,
      input pkt_delay,
      input pkt_refresh,
      input pkt_dual,
      input pkt_bank2
   );
endinterface

// ===== core/row_cmd_target.sv
// Purpose: Device end: checks packet spacing per bank set and executes commands
// Assumes: Link signals come from logic on the same clock
// Notes: A packet that breaks a gap is dropped and flagged
`timescale 1ns/10ps
module row_cmd_target #(
   parameter logic [row_spacing_pkg::AGE_W-1:0] OPEN_GAP_SAME = row_spacing_pkg::OPEN_GAP_SAME,
   parameter logic [row_spacing_pkg::AGE_W-1:0] OPEN_GAP_CROSS = row_spacing_pkg::OPEN_GAP_CROSS,
   parameter logic [row_spacing_pkg::AGE_W-1:0] CLOSE_GAP_SAME = row_spacing_pkg::CLOSE_GAP_SAME,
   parameter logic [row_spacing_pkg::AGE_W-1:0] CLOSE_GAP_CROSS = row_spacing_pkg::CLOSE_GAP_CROSS
)(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   row_link_if.dev link,
   output logic [row_spacing_pkg::SETS-1:0] o_open_exec,
   output logic [row_spacing_pkg::SETS-1:0] o_open_refresh,
   output logic [row_spacing_pkg::SETS*row_spacing_pkg::BANK_W-1:0] o_open_bank,
   output logic [row_spacing_pkg::SETS-1:0] o_close_exec,
   output logic [row_spacing_pkg::SETS-1:0] o_close_refresh,
   output logic [row_spacing_pkg::SETS*row_spacing_pkg::BANK_W-1:0] o_close_bank,
   output logic o_gap_err
);
   localparam int BW = row_spacing_pkg::BANK_W;
   localparam int AW = row_spacing_pkg::AGE_W;
   // Shorter cross-set gaps are not supported here, so they are raised
   localparam logic [AW-1:0] OCG = (OPEN_GAP_CROSS < row_spacing_pkg::DEV_MIN_OPEN_CROSS) ?
      row_spacing_pkg::DEV_MIN_OPEN_CROSS : OPEN_GAP_CROSS;
   localparam logic [AW-1:0] CCG = (CLOSE_GAP_CROSS < row_spacing_pkg::DEV_MIN_CLOSE_CROSS) ?
      row_spacing_pkg::DEV_MIN_CLOSE_CROSS : CLOSE_GAP_CROSS;

   logic set_a;
   logic set_b;
   logic is_open;
   logic is_close;
   logic open_ok;
   logic close_ok;
   logic take_open;
   logic take_close;
   logic [AW-1:0] open_age_q [row_spacing_pkg::SETS];
   logic [AW-1:0] close_age_q [row_spacing_pkg::SETS];

   assign set_a = link.pkt_bank[row_spacing_pkg::SET_BIT]; // [R01]
   assign set_b = link.pkt_bank2[row_spacing_pkg::SET_BIT]; // [R01]
   assign is_open = link.pkt_valid && (link.pkt_kind == row_spacing_pkg::KIND_OPEN);
   assign is_close = link.pkt_valid && (link.pkt_kind == row_spacing_pkg::KIND_CLOSE);
   assign open_ok = (open_age_q[set_a] >= OPEN_GAP_SAME) && (open_age_q[~set_a] >= OCG); // [R08]
   // Dual close must hit both sets, each checked against its own last close
   assign close_ok = link.pkt_dual ?
      ((set_a != set_b) && (close_age_q[0] >= CLOSE_GAP_SAME) &&
       (close_age_q[1] >= CLOSE_GAP_SAME)) :
      ((close_age_q[set_a] >= CLOSE_GAP_SAME) && (close_age_q[~set_a] >= CCG)); // [R15] [R16]
   assign take_open = is_open && open_ok;
   assign take_close = is_close && close_ok;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_gap_err <= 1'b0;
      else
         o_gap_err <= (is_open && !open_ok) || (is_close && !close_ok);
   end

   for (genvar s = 0; s < row_spacing_pkg::SETS; s++)
   begin : g_set
      logic open_hit;
      logic close_hit;
      logic close_hit2;
      logic open_pend_q;
      logic close_pend_q;
      logic open_pend_ref_q;
      logic close_pend_ref_q;
      logic [BW-1:0] open_pend_bank_q;
      logic [BW-1:0] close_pend_bank_q;
      assign open_hit = take_open && (set_a == 1'(s));
      assign close_hit = take_close && (set_a == 1'(s));
      assign close_hit2 = take_close && link.pkt_dual && (set_b == 1'(s)); // [R15]

      always_ff @(posedge i_ref_clk)
      begin
         if (i_srst)
         begin
            open_age_q[s] <= row_spacing_pkg::AGE_MAX;
            close_age_q[s] <= row_spacing_pkg::AGE_MAX;
         end
         else
         begin
            open_age_q[s] <= open_hit ? row_spacing_pkg::AGE_ONE :
               (open_age_q[s] == row_spacing_pkg::AGE_MAX) ? open_age_q[s] :
               open_age_q[s] + row_spacing_pkg::AGE_ONE;
            close_age_q[s] <= (close_hit || close_hit2) ? row_spacing_pkg::AGE_ONE :
               (close_age_q[s] == row_spacing_pkg::AGE_MAX) ? close_age_q[s] :
               close_age_q[s] + row_spacing_pkg::AGE_ONE;
         end
      end

      // One-cycle issue delay holds the command for the next edge
      always_ff @(posedge i_ref_clk)
      begin
         if (i_srst)
         begin
            open_pend_q <= 1'b0;
            close_pend_q <= 1'b0;
            open_pend_ref_q <= 1'b0;
            close_pend_ref_q <= 1'b0;
            open_pend_bank_q <= '0;
            close_pend_bank_q <= '0;
         end
         else
         begin
            open_pend_q <= open_hit && link.pkt_delay; // [R07]
            // Both closes of a delayed dual packet wait, so they still share one edge
            close_pend_q <= (close_hit || close_hit2) && link.pkt_delay; // [R14] [R15]
            open_pend_ref_q <= link.pkt_refresh;
            close_pend_ref_q <= !close_hit2 && link.pkt_refresh;
            open_pend_bank_q <= link.pkt_bank;
            close_pend_bank_q <= close_hit2 ? link.pkt_bank2 : link.pkt_bank;
         end
      end

      always_ff @(posedge i_ref_clk)
      begin
         if (i_srst)
         begin
            o_open_exec[s] <= 1'b0;
            o_open_refresh[s] <= 1'b0;
            o_open_bank[s*BW +: BW] <= '0;
            o_close_exec[s] <= 1'b0;
            o_close_refresh[s] <= 1'b0;
            o_close_bank[s*BW +: BW] <= '0;
         end
         else
         begin
            o_open_exec[s] <= (open_hit && !link.pkt_delay) || open_pend_q; // [R07]
            o_open_refresh[s] <= open_pend_q ? open_pend_ref_q : link.pkt_refresh;
            o_open_bank[s*BW +: BW] <= open_pend_q ? open_pend_bank_q : link.pkt_bank;
            o_close_exec[s] <= ((close_hit || close_hit2) && !link.pkt_delay) || close_pend_q;
            // Refresh tag belongs to the first close of a dual packet
            o_close_refresh[s] <= close_pend_q ? close_pend_ref_q :
               (!close_hit2 && link.pkt_refresh);
            o_close_bank[s*BW +: BW] <= close_pend_q ? close_pend_bank_q :
               close_hit2 ? link.pkt_bank2 : link.pkt_bank;
         end
      end
   end
endmodule

// ===== core/row_cmd_issuer.sv
// Purpose: Controller end: spaces row open and row close packets per bank set
// Assumes: User request fields stand while i_req_valid is high
// Notes: Ready is combinational; packet fields leave from flops
`timescale 1ns/10ps
// Operation
// (R01) Bank set chosen by bank bit zero
// (R02) Same-set opens spaced by same-set gap
// (R03) Cross-set opens spaced by cross-set gap
// (R04) Both gaps four: no open interleaving
// (R05) Cross gap two: open inserted between; code raises the open cross gap to four, so none is inserted
// (R06) Cross gap one: insert need not centre; code raises the open cross gap to four
// (R07) Cross gap zero uses one-cycle delay; code raises the open cross gap to four instead
// (R08) Device needs cross open gap four
// (R09) Same-set closes spaced by same-set gap
// (R10) Cross-set closes spaced by cross gap
// (R11) Both close gaps four: same spacing
// (R12) Close cross gap two allows insertion
// (R13) Close cross gap one: off-centre allowed
// (R14) Close cross gap zero uses delay; code raises the close cross gap to one instead
// (R15) Dual close packet hits both sets
// (R16) Device cross close gap at least one
// (R17) Track last open/close per set
module row_cmd_issuer #(
   parameter logic [row_spacing_pkg::AGE_W-1:0] OPEN_GAP_SAME = row_spacing_pkg::OPEN_GAP_SAME,
   parameter logic [row_spacing_pkg::AGE_W-1:0] OPEN_GAP_CROSS = row_spacing_pkg::OPEN_GAP_CROSS,
   parameter logic [row_spacing_pkg::AGE_W-1:0] CLOSE_GAP_SAME = row_spacing_pkg::CLOSE_GAP_SAME,
   parameter logic [row_spacing_pkg::AGE_W-1:0] CLOSE_GAP_CROSS = row_spacing_pkg::CLOSE_GAP_CROSS
)(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_req_valid,
   input wire row_spacing_pkg::pkt_kind_t i_req_kind,
   input wire logic [row_spacing_pkg::BANK_W-1:0] i_req_bank,
   input wire logic i_req_delay,
   input wire logic i_req_refresh,
   input wire logic i_req_dual,
   input wire logic [row_spacing_pkg::BANK_W-1:0] i_req_bank2,
   output logic o_req_ready,
   output logic o_req_bad,
   row_link_if.ctrl link
);
   localparam int AW = row_spacing_pkg::AGE_W;
   // Gaps below what the device accepts are raised; the short cases stay unused
   localparam logic [AW-1:0] OCG = (OPEN_GAP_CROSS < row_spacing_pkg::DEV_MIN_OPEN_CROSS) ?
      row_spacing_pkg::DEV_MIN_OPEN_CROSS : OPEN_GAP_CROSS; // [R08]
   localparam logic [AW-1:0] CCG = (CLOSE_GAP_CROSS < row_spacing_pkg::DEV_MIN_CLOSE_CROSS) ?
      row_spacing_pkg::DEV_MIN_CLOSE_CROSS : CLOSE_GAP_CROSS; // [R16]

   typedef enum logic [1:0]
   {
      ST_RESET = 2'h0,
      ST_RUN = 2'h1
   } ctl_state_t;

   ctl_state_t state_q;
   ctl_state_t state_d;
   logic set_a;
   logic set_b;
   logic is_open;
   logic is_close;
   logic open_ok;
   logic close_single_ok;
   logic close_dual_ok;
   logic close_ok;
   logic shape_ok;
   logic go;
   logic go_open;
   logic go_close;
   logic [AW-1:0] open_age_q [row_spacing_pkg::SETS];
   logic [AW-1:0] close_age_q [row_spacing_pkg::SETS];
   logic [row_spacing_pkg::SETS-1:0] open_hit;
   logic [row_spacing_pkg::SETS-1:0] close_hit;

   // Hold off one cycle after reset so ages are settled
   always_comb
   begin
      case (state_q)
         ST_RESET: state_d = ST_RUN;
         ST_RUN: state_d = ST_RUN;
         default: state_d = ST_RESET;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         state_q <= ST_RESET;
      else
         state_q <= state_d;
   end

   assign set_a = i_req_bank[row_spacing_pkg::SET_BIT]; // [R01]
   assign set_b = i_req_bank2[row_spacing_pkg::SET_BIT]; // [R01]
   assign is_open = (i_req_kind == row_spacing_pkg::KIND_OPEN);
   assign is_close = (i_req_kind == row_spacing_pkg::KIND_CLOSE);

   // Same-set gap and cross-set gap are separate minimums
   assign open_ok = (open_age_q[set_a] >= OPEN_GAP_SAME) && // [R02] [R04]
      (open_age_q[~set_a] >= OCG); // [R03] [R05] [R06]
   assign close_single_ok = (close_age_q[set_a] >= CLOSE_GAP_SAME) && // [R09] [R11]
      (close_age_q[~set_a] >= CCG); // [R10] [R12] [R13]
   // Both closes in one packet execute on one edge, so each set needs its own gap
   assign close_dual_ok = (set_a != set_b) && (close_age_q[0] >= CLOSE_GAP_SAME) &&
      (close_age_q[1] >= CLOSE_GAP_SAME); // [R15]
   assign close_ok = i_req_dual ? close_dual_ok : close_single_ok;

   // Dual on an open, same-set dual close, or idle kind can never be sent
   assign shape_ok = (is_open && !i_req_dual) || (is_close && (!i_req_dual || (set_a != set_b)));
   assign o_req_bad = i_req_valid && !shape_ok;

   assign o_req_ready = (state_q == ST_RUN) && shape_ok &&
      ((is_open && open_ok) || (is_close && close_ok)); // [R17]
   assign go = i_req_valid && o_req_ready;
   assign go_open = go && is_open;
   assign go_close = go && is_close;

   for (genvar s = 0; s < row_spacing_pkg::SETS; s++)
   begin : g_age
      logic [AW-1:0] open_age_d;
      logic [AW-1:0] close_age_d;

      assign open_hit[s] = go_open && (set_a == 1'(s));
      assign close_hit[s] = go_close &&
         ((set_a == 1'(s)) || (i_req_dual && (set_b == 1'(s)))); // [R15]

      // Cycles since the last packet to this set; saturating so idle never wraps
      always_comb
      begin
         open_age_d = open_age_q[s];
         if (open_hit[s])
            open_age_d = row_spacing_pkg::AGE_ONE; // [R17]
         else if (open_age_q[s] != row_spacing_pkg::AGE_MAX)
            open_age_d = open_age_q[s] + row_spacing_pkg::AGE_ONE;
      end

      always_comb
      begin
         close_age_d = close_age_q[s];
         if (close_hit[s])
            close_age_d = row_spacing_pkg::AGE_ONE; // [R17]
         else if (close_age_q[s] != row_spacing_pkg::AGE_MAX)
            close_age_d = close_age_q[s] + row_spacing_pkg::AGE_ONE;
      end

      always_ff @(posedge i_ref_clk)
      begin
         if (i_srst)
            open_age_q[s] <= row_spacing_pkg::AGE_MAX;
         else
            open_age_q[s] <= open_age_d;
      end

      always_ff @(posedge i_ref_clk)
      begin
         if (i_srst)
            close_age_q[s] <= row_spacing_pkg::AGE_MAX;
         else
            close_age_q[s] <= close_age_d;
      end
   end

   // Packet leaves one cycle after acceptance; spacing is kept since delay is fixed
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         link.pkt_valid <= 1'b0;
      else
         link.pkt_valid <= go;
   end

   // Kind and qualifiers drop back to idle so a stale field never reads as a command
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         link.pkt_kind <= row_spacing_pkg::KIND_IDLE;
         link.pkt_delay <= 1'b0;
         link.pkt_dual <= 1'b0;
      end
      else if (go)
      begin
         link.pkt_kind <= i_req_kind;
         link.pkt_delay <= i_req_delay; // [R07] [R14]
         link.pkt_dual <= go_close && i_req_dual; // [R15]
      end
      else
      begin
         link.pkt_kind <= row_spacing_pkg::KIND_IDLE;
         link.pkt_delay <= 1'b0;
         link.pkt_dual <= 1'b0;
      end
   end

   // Payload holds between packets; it means nothing without pkt_valid
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         link.pkt_bank <= '0;
         link.pkt_refresh <= 1'b0;
         link.pkt_bank2 <= '0;
      end
      else if (go)
      begin
         link.pkt_bank <= i_req_bank;
         link.pkt_refresh <= i_req_refresh;
         link.pkt_bank2 <= i_req_bank2;
      end
   end
endmodule

// ===== tb/row_link_sva.sv
// Purpose: Checks packet spacing and shape on the issuer to target link
// Assumes: One clock, synchronous reset active high
// Notes: Sees only link signals, so execution timing is left to the bench
`timescale 1ns/10ps
module row_link_sva (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic pkt_valid,
   input wire row_spacing_pkg::pkt_kind_t pkt_kind,
   input wire logic [row_spacing_pkg::BANK_W-1:0] pkt_bank,
   input wire logic pkt_delay,
   input wire logic pkt_refresh,
   input wire logic pkt_dual,
   input wire logic [row_spacing_pkg::BANK_W-1:0] pkt_bank2
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   logic op;
   logic cl;
   logic rst_q;
   logic [1:0] cls;
   assign op = pkt_valid && pkt_kind == row_spacing_pkg::KIND_OPEN;
   assign cl = pkt_valid && pkt_kind == row_spacing_pkg::KIND_CLOSE;
   // A dual close touches both sets at once
   assign cls[0] = cl && (!pkt_bank[0] || pkt_dual && !pkt_bank2[0]);
   assign cls[1] = cl && (pkt_bank[0] || pkt_dual && pkt_bank2[0]);
   always_ff @(posedge i_ref_clk)
   begin
      rst_q <= i_srst;
   end
   chk_open_spacing: assert property (op |=> (!op) [*3])
      else $error("open packets closer than four cycles");
   chk_close_same0: assert property (cls[0] |=> (!cls[0]) [*3])
      else $error("even set closes closer than four cycles");
   chk_close_same1: assert property (cls[1] |=> (!cls[1]) [*3])
      else $error("odd set closes closer than four cycles");
   chk_dual_split: assert property (cl && pkt_dual |-> pkt_bank[0] != pkt_bank2[0])
      else $error("dual close aimed at one set");
   chk_dual_kind: assert property (pkt_valid && pkt_dual |-> cl)
      else $error("dual flag on a non close packet");
   chk_dual_close_gap: assert property (cl && pkt_dual |=> (!cl) [*3])
      else $error("close too soon after a dual close");
   chk_reset_quiet: assert property (rst_q |-> !pkt_valid)
      else $error("packet right after reset");
   chk_idle_kind: assert property (!pkt_valid |-> pkt_kind == row_spacing_pkg::KIND_IDLE)
      else $error("kind not idle between packets");
endmodule

// ===== tb/tb_top.sv
// Purpose: Random and corner traffic through issuer, link and target
// Assumes: 100 MHz clock, synchronous reset active high
// Notes: A second link lets the bench break gaps on purpose
`timescale 1ns/10ps
module tb_top;
   localparam row_spacing_pkg::pkt_kind_t k_idle = row_spacing_pkg::KIND_IDLE;
   localparam row_spacing_pkg::pkt_kind_t k_open = row_spacing_pkg::KIND_OPEN;
   localparam row_spacing_pkg::pkt_kind_t k_close = row_spacing_pkg::KIND_CLOSE;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic rv = 1'b0;
   row_spacing_pkg::pkt_kind_t rk = k_idle;
   logic [2:0] rb = 3'h0;
   logic [2:0] rb2 = 3'h0;
   logic rd = 1'b0;
   logic rr = 1'b0;
   logic ru = 1'b0;
   logic rdy, bad, gerr, gerr2, nq;
   logic [1:0] oe, orf, ce, crf, oe2, ce2;
   logic [5:0] ob, cb;
   logic [3:0] ao [2];
   logic [3:0] ac [2];
   logic [19:0] st1, st2;
   logic [10:0] pk;
   logic pend = 1'b0;
   int seed = 51762;
   int err_total = 0;
   int checks_done = 0;
   int wt = 0;
   int ph = 0;
   int hq = 3;
   int ci = 0;
   // Dual close, cross closes, delayed open, refresh open, then three bad shapes
   logic [10:0] corner [8] = '{11'h69D, 11'h700, 11'h640, 11'h2E0, 11'h210, 11'h68C,
      11'h040, 11'h24A};
   row_link_if link();
   row_link_if link2();
   row_cmd_issuer u_row_cmd_issuer (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req_valid(rv),
      .i_req_kind(rk), .i_req_bank(rb), .i_req_delay(rd), .i_req_refresh(rr), .i_req_dual(ru),
      .i_req_bank2(rb2), .o_req_ready(rdy), .o_req_bad(bad), .link(link));
   row_cmd_target u_row_cmd_target (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(link),
      .o_open_exec(oe), .o_open_refresh(orf), .o_open_bank(ob), .o_close_exec(ce),
      .o_close_refresh(crf), .o_close_bank(cb), .o_gap_err(gerr));
   row_cmd_target u_row_cmd_target_2 (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(link2),
      .o_open_exec(oe2), .o_open_refresh(), .o_open_bank(), .o_close_exec(ce2),
      .o_close_refresh(), .o_close_bank(), .o_gap_err(gerr2));
   row_link_sva u_row_link_sva (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
      .pkt_valid(link.pkt_valid), .pkt_kind(link.pkt_kind), .pkt_bank(link.pkt_bank),
      .pkt_delay(link.pkt_delay), .pkt_refresh(link.pkt_refresh), .pkt_dual(link.pkt_dual),
      .pkt_bank2(link.pkt_bank2));
   always #5 i_ref_clk = ~i_ref_clk;
   task automatic chk(string nm, logic [19:0] ex, logic [19:0] got);
      checks_done++;
      if (got !== ex)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Bank and refresh only mean something beside an exec bit
   function automatic logic [19:0] msk(logic [19:0] v);
      for (int s = 0; s < 2; s++)
      begin
         if (!v[18+s]) {v[16+s], v[10+3*s+:3]} = 4'h0;
         if (!v[8+s]) {v[6+s], v[3*s+:3]} = 4'h0;
      end
      return v;
   endfunction
   function automatic logic [19:0] put(logic [19:0] v, logic [10:0] p);
      logic s;
      s = p[6];
      if (p[10:9] == 2'h1)
         {v[18+s], v[16+s], v[10+3*s+:3]} = {1'b1, p[4], p[8:6]};
      else
         {v[8+s], v[6+s], v[3*s+:3]} = {1'b1, p[4], p[8:6]};
      if (p[3])
         {v[8+p[0]], v[3*p[0]+:3]} = {1'b1, p[2:0]};
      return v;
   endfunction
   // Returns bad and ready for the request now offered
   function automatic logic [1:0] exp_rdy();
      logic s;
      s = rb[0];
      if (rk == k_idle || (ru && (rk == k_open || rb2[0] == s))) return 2'h2;
      if (rk == k_open) return {1'b0, ao[s] >= 4 && ao[!s] >= 4};
      if (ru) return {1'b0, ac[0] >= 4 && ac[1] >= 4};
      return {1'b0, ac[s] >= 4 && ac[!s] >= 1};
   endfunction
   task automatic pick();
      logic [31:0] r;
      logic [10:0] v;
      r = $random(seed);
      v = {r[7:4] == 4'h0 ? 2'h0 : (r[2] ? 2'h1 : 2'h3), r[12:8], r[13] & r[14] & !r[2],
         r[16:15], !r[8] ^ (r[7:5] == 3'h0)};
      rv = r[1:0] != 2'h0;
      if (ph == 1 && ci < 8)
      begin
         v = corner[ci];
         ci++;
         rv = 1'b1;
      end
      rk = row_spacing_pkg::pkt_kind_t'(v[10:9]);
      {rb, rd, rr, ru, rb2} = v[8:0];
   endtask
   always @(posedge i_ref_clk)
   begin
      #1;
      if (ph == 0 || hq != 0 || i_srst) rv = 1'b0;
      else if (nq) pick();
   end
   always @(negedge i_ref_clk)
   begin
      logic [1:0] ex;
      logic acc;
      logic [19:0] t;
      ex = exp_rdy();
      if (i_srst)
      begin
         ao = '{4'hF, 4'hF};
         ac = '{4'hF, 4'hF};
         {st1, st2, pend, nq, wt, hq} = {40'h0, 1'b0, 1'b1, 32'd0, 32'd3};
      end
      else
      begin
         if (hq != 0) hq--;
         t = {11'h0, link.pkt_valid, link.pkt_kind, link.pkt_bank, link.pkt_delay,
            link.pkt_refresh, link.pkt_dual};
         if (!link.pkt_valid) t[5:0] = 6'h0;
         chk("link", {11'h0, pend, pend ? pk[10:3] : 8'h0}, t);
         chk("exec", st1, msk({oe, orf, ob, ce, crf, cb}));
         chk("gap_err", 20'h0, {19'h0, gerr});
         st1 = st2;
         st2 = 20'h0;
         if (pend && pk[5]) st2 = put(st2, pk);
         if (pend && !pk[5]) st1 = put(st1, pk);
         if (rv) chk("ready", {18'h0, ex}, {18'h0, bad, rdy});
         acc = rv && rdy === 1'b1;
         for (int s = 0; s < 2; s++)
         begin
            ao[s] = ao[s] + {3'h0, ao[s] != 4'hF};
            ac[s] = ac[s] + {3'h0, ac[s] != 4'hF};
            if (acc && rk == k_open && rb[0] == s) ao[s] = 4'h1;
            if (acc && rk == k_close && (rb[0] == s || ru && rb2[0] == s)) ac[s] = 4'h1;
         end
         pend = acc;
         pk = {rk, rb, rd, rr, ru, rb2};
         wt = (acc || !rv) ? 0 : wt + 1;
         nq = acc || !rv || wt == 12;
         // A legal request never waits this long; only bad shapes may
         if (wt == 12) chk("stall", {19'h0, ex[1]}, 20'h1);
         if (nq) wt = 0;
      end
   end
   task automatic put2(row_spacing_pkg::pkt_kind_t k, logic [2:0] b, logic du, logic [2:0] b2,
      logic e);
      {link2.pkt_valid, link2.pkt_kind, link2.pkt_bank, link2.pkt_dual} = {1'b1, k, b, du};
      link2.pkt_bank2 = b2;
      @(posedge i_ref_clk);
      #1;
      {link2.pkt_valid, link2.pkt_kind, link2.pkt_bank} = {1'b0, k_idle, ~b};
      @(negedge i_ref_clk);
      chk("fault", {18'h0, e, !e}, {18'h0, gerr2, |{oe2, ce2}});
      @(posedge i_ref_clk);
      #1;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      {link2.pkt_valid, link2.pkt_kind, link2.pkt_bank, link2.pkt_dual} = {1'b0, k_idle, 4'h0};
      {link2.pkt_delay, link2.pkt_refresh, link2.pkt_bank2} = 5'h0;
      repeat (5) @(posedge i_ref_clk);
      #1;
      i_srst = 1'b0;
      ph = 1;
      for (int n = 0; n < 200 && ci < 8; n++) @(posedge i_ref_clk);
      chk("corner", 20'h8, ci[19:0]);
      $display("test corner done");
      ph = 2;
      repeat (3000) @(posedge i_ref_clk);
      $display("test random done");
      ph = 0;
      @(posedge i_ref_clk);
      #1;
      i_srst = 1'b1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      i_srst = 1'b0;
      ph = 2;
      repeat (300) @(posedge i_ref_clk);
      ph = 0;
      $display("test reset done");
      repeat (8) @(posedge i_ref_clk);
      #1;
      put2(k_open, 3'h0, 1'b0, 3'h0, 1'b0);
      put2(k_open, 3'h3, 1'b0, 3'h0, 1'b1);
      put2(k_close, 3'h2, 1'b1, 3'h4, 1'b1);
      put2(k_close, 3'h5, 1'b1, 3'h2, 1'b0);
      $display("test fault done");
      conclude();
   end
endmodule
